// ===== verif/test_adc_conversion_control.sv
`timescale 1ns/1ps
`include "acc_map.svh"

module test_adc_conversion_control;
    import acc_pkg::*;

    typedef struct packed {
        logic [1:0] sel;
        logic [2:0] chan;
        logic just;
        logic [3:0] pcfg;
        logic [9:0] vin;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [4:0] an;
        logic vh;
        logic vl;
        logic [5:0] n;
    } acc_row_t;

    localparam logic [11:0] A_CA = {2'h0, `ACC_IDX_CTRL_A, 2'h0};
    localparam logic [11:0] A_CB = {2'h0, `ACC_IDX_CTRL_B, 2'h0};
    localparam logic [11:0] A_HI = {2'h0, `ACC_IDX_RES_HI, 2'h0};
    localparam logic [11:0] A_LO = {2'h0, `ACC_IDX_RES_LO, 2'h0};
    localparam logic [11:0] A_ST = {2'h0, `ACC_IDX_STATUS, 2'h0};

    logic clk = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic sleep = 1'h0;
    logic rc = 1'h0;
    logic [9:0] vin = 10'h000;
    logic pready, pslverr, vh, vl, powered, sample, done;
    logic [31:0] prdata;
    logic [2:0] chan;
    logic [4:0] an;
    logic [9:0] dac;
    logic [31:0] rd;
    logic er;
    int fails = 0;
    int n_tests = 0;

    // ==========================================================
    // rows: sel chan just pcfg vin hi lo analog vh vl tad
    acc_row_t rows [6] = '{
        '{2'h0, 3'h0, 1'h1, 4'h0, 10'h3FF, 8'h03, 8'hFF, 5'h1F, 1'h0, 1'h0, 6'h02},
        '{2'h1, 3'h1, 1'h0, 4'h1, 10'h2A5, 8'hA9, 8'h40, 5'h1F, 1'h1, 1'h0, 6'h08},
        '{2'h2, 3'h4, 1'h1, 4'h8, 10'h15A, 8'h01, 8'h5A, 5'h1F, 1'h1, 1'h1, 6'h20},
        '{2'h3, 3'h2, 1'h1, 4'h4, 10'h0C3, 8'h00, 8'hC3, 5'h0B, 1'h0, 1'h0, 6'h14},
        '{2'h1, 3'h3, 1'h0, 4'h6, 10'h000, 8'h00, 8'h00, 5'h00, 1'h0, 1'h0, 6'h08},
        '{2'h1, 3'h0, 1'h1, 4'hF, 10'h3FF, 8'h03, 8'hFF, 5'h0D, 1'h1, 1'h1, 6'h08}
    };

    always #50 clk = ~clk;
    // rc oscillator, toggles every 10 clocks: 20 clock periods
    int rc_cnt = 0;
    always @(posedge clk)
    begin
        rc_cnt <= (rc_cnt == 9) ? 0 : rc_cnt + 1;
        if (rc_cnt == 9)
            rc <= ~rc;
    end

    acc_conv_ctrl dut (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_sleep(sleep),
        .i_cmp(vin >= dac), .i_rc_osc(rc), .o_chan_sel(chan), .o_pin_analog(an),
        .o_vref_hi_pin(vh), .o_vref_lo_pin(vl), .o_powered(powered),
        .o_sample(sample), .o_dac_code(dac), .o_done_flag(done)
    );

    // ==========================================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'h1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        chk("pready", {31'h0, k < 50}, 32'h1);
    endtask

    task automatic wait_done();
        int k;
        k = 0;
        while (done !== 1'h1 && k < 1000)
        begin
            @(posedge clk);
            k++;
        end
        chk("done_wait", {31'h0, k < 1000}, 32'h1);
    endtask

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        xfer(1'h0, a, 8'h00);
        chk(nm, rd, exp);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        print_verdict();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        acc_row_t r;
        logic [7:0] ca;
        longint t0;
        int n;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        #1;
        chk("an_rst", {27'h0, an}, 32'h1F);
        chk("pwr_rst", {31'h0, powered}, 32'h0);
        rdchk("ca_rst", A_CA, 32'h0);
        rdchk("cb_rst", A_CB, 32'h0);
        xfer(1'h0, 12'h100, 8'h00);
        chk("unmapped", {er, rd[30:0]}, 32'h80000000);
        xfer(1'h1, A_CA, 8'h04);
        repeat (300) @(posedge clk);
        #1;
        chk("off_done", {31'h0, done}, 32'h0);
        chk("off_pwr", {31'h0, powered}, 32'h0);
        rdchk("off_busy", A_ST, 32'h0);
        $display("test reset and off done");
        for (int i = 0; i < 6; i++)
        begin
            r = rows[i];
            ca = {r.sel, r.chan, 3'h1};
            xfer(1'h1, A_CB, {r.just, 3'h0, r.pcfg});
            xfer(1'h1, A_CA, ca);
            vin <= r.vin;
            xfer(1'h1, A_ST, 8'h00);
            #1;
            chk("done_clr", {31'h0, done}, 32'h0);
            chk("chan", {29'h0, chan}, {29'h0, r.chan});
            chk("analog", {27'h0, an}, {27'h0, r.an});
            chk("refs", {30'h0, vh, vl}, {30'h0, r.vh, r.vl});
            chk("powered", {31'h0, powered}, 32'h1);
            repeat (200) @(posedge clk);
            t0 = $time;
            xfer(1'h1, A_CA, ca | 8'h04);
            rdchk("go_busy", A_CA, {24'h0, ca | 8'h04});
            wait_done();
            n = int'(($time - t0) / 64'd100);
            chk("conv_len", {31'h0, n >= 11 * r.n && n <= 13 * r.n + 6}, 32'h1);
            rdchk("go_clr", A_CA, {24'h0, ca});
            rdchk("res_hi", A_HI, {24'h0, r.hi});
            rdchk("res_lo", A_LO, {24'h0, r.lo});
            rdchk("cb", A_CB, {24'h0, r.just, 3'h0, r.pcfg});
            rdchk("status", A_ST, 32'h1);
            $display("row %0d done", i);
        end
        xfer(1'h1, A_ST, 8'h00);
        vin <= 10'h000;
        xfer(1'h1, A_CA, 8'h45);
        repeat (30) @(posedge clk);
        xfer(1'h1, A_CA, 8'h41);
        repeat (200) @(posedge clk);
        #1;
        chk("abort_done", {31'h0, done}, 32'h0);
        chk("abort_acq", {31'h0, sample}, 32'h1);
        rdchk("abort_hi", A_HI, 32'h03);
        rdchk("abort_lo", A_LO, 32'hFF);
        $display("test abort done");
        xfer(1'h1, A_CA, 8'h45);
        repeat (20) @(posedge clk);
        sleep <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        chk("sleep_pwr", {31'h0, powered}, 32'h0);
        repeat (150) @(posedge clk);
        #1;
        chk("sleep_done", {31'h0, done}, 32'h0);
        rdchk("sleep_st", A_ST, 32'h0);
        xfer(1'h0, A_CA, 8'h00);
        chk("sleep_on", {31'h0, rd[0]}, 32'h1);
        sleep <= 1'h0;
        vin <= 10'h155;
        xfer(1'h1, A_CA, 8'hC1);
        xfer(1'h1, A_CA, 8'hC5);
        sleep <= 1'h1;
        wait_done();
        #1;
        chk("rc_sleep", {31'h0, done}, 32'h1);
        sleep <= 1'h0;
        rdchk("rc_hi", A_HI, 32'h01);
        rdchk("rc_lo", A_LO, 32'h55);
        $display("test sleep done");
        xfer(1'h1, A_CB, 8'hFF);
        rdchk("cb_rsv", A_CB, 32'h8F);
        xfer(1'h1, A_CA, 8'h43);
        rdchk("ca_rsv", A_CA, 32'h41);
        xfer(1'h1, A_CA, 8'h45);
        repeat (10) @(posedge clk);
        rst <= 1'h1;
        repeat (5) @(posedge clk);
        #1;
        chk("rst_pwr", {30'h0, powered, sample}, 32'h0);
        chk("rst_an", {27'h0, an}, 32'h1F);
        chk("rst_done", {18'h0, dac, done, chan}, 32'h0);
        @(posedge clk);
        rst <= 1'h0;
        rdchk("rst_ca", A_CA, 32'h0);
        rdchk("rst_cb", A_CB, 32'h0);
        rdchk("rst_st", A_ST, 32'h0);
        $display("test mid reset done");
        print_verdict();
    end

endmodule

// ===== verilog/acc_conv_ctrl.sv
// Overview of operation
// - per-bit clock is oscillator /2, /8, /32 or internal rc by select code.
// - three-bit channel select routes one of five analog inputs.
// - writing go with converter on starts conversion; go reads one while running.
// - hardware clears go at end of conversion.
// - completion loads result, clears go and sets done flag together.
// - converter-on bit enables module; clear shuts it off.
// - unimplemented control bits read zero.
// - format one right-justifies, six upper high bits zero.
// - format zero left-justifies, six lower low bits zero.
// - four-bit field decides analog or digital per shared pin.
// - same field selects upper and lower reference sources.
// - conversion in sleep needs the internal rc clock selected.
// - clearing go mid-conversion aborts, keeps result, restarts acquisition.
// - conversion takes twelve per-bit periods.
// - rc clock waits one instruction cycle; other clocks abort on sleep.
// - reset turns converter off, aborts, makes all pins analog.
`timescale 1ns/1ps
`include "acc_map.svh"

module acc_conv_ctrl
    import acc_pkg::*;
(
    input logic i_ref_clk,           // 10 MHz clock
    input logic i_sys_rst,           // sync reset, active high
    input logic i_psel,              // apb select
    input logic i_penable,           // apb enable
    input logic i_pwrite,            // apb write
    input logic [11:0] i_paddr,      // apb byte address
    input logic [31:0] i_pwdata,     // apb write data
    output logic o_pready,           // apb ready
    output logic [31:0] o_prdata,    // apb read data
    output logic o_pslverr,          // apb error, unmapped address
    input logic i_sleep,             // device in sleep
    input logic i_cmp,               // comparator, input above dac
    input logic i_rc_osc,            // internal rc oscillator
    output logic [2:0] o_chan_sel,   // analog mux select
    output logic [4:0] o_pin_analog, // per pin analog enable
    output logic o_vref_hi_pin,      // upper reference from pin
    output logic o_vref_lo_pin,      // lower reference from pin
    output logic o_powered,          // converter powered
    output logic o_sample,           // hold cap tracking input
    output logic [9:0] o_dac_code,   // sar trial code
    output logic o_done_flag         // conversion done flag
);

    acc_ctl_t ctl_reg;
    acc_ctl_t ctl_next;
    logic tad;
    logic fin;
    logic setup;
    logic access;
    logic hit;
    logic [7:0] idx;
    logic [3:0] bidx;
    logic [6:0] pdec;
    localparam logic [7:0] CA_RST = `ACC_CTRL_A_RST;
    localparam logic [7:0] CB_RST = `ACC_CTRL_B_RST;

    // ==========================================================
    // pin configuration decode {vref hi pin, vref lo pin, analog}
    function automatic logic [6:0] pin_decode(input logic [3:0] c);
        logic [6:0] r;
        r = 7'h1F;
        unique case (c)
            4'h1, 4'h3, 4'hA: r = 7'h5F;
            4'h4: r = 7'h0B;
            4'h5: r = 7'h4B;
            4'h6, 4'h7: r = 7'h00;
            4'h8, 4'hB, 4'hC: r = 7'h7F;
            4'hD: r = 7'h6F;
            4'hE: r = 7'h01;
            4'hF: r = 7'h6D;
            default: r = 7'h1F;
        endcase
        return r;
    endfunction

    // ==========================================================
    // per-bit clock
    acc_tad_div u_tad
    (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_run(ctl_reg.st == ACC_ST_CONV),
        .i_sel(ctl_reg.clk_sel),
        .i_rc_lvl(ctl_reg.rc_f),
        .o_tad(tad)
    );

    // ==========================================================
    // next state
    always_comb
    begin
        ctl_next = ctl_reg;
        idx = i_paddr[9:2];
        hit = (i_paddr[11:10] == 2'h0) && (i_paddr[1:0] == 2'h0);
        setup = i_psel && !i_penable;
        access = i_psel && i_penable && ctl_reg.pready;
        fin = 1'b0;
        bidx = 4'h0;
        // pin synchronisers, change taken when stages two and three agree
        ctl_next.cmp_sy = {ctl_reg.cmp_sy[1:0], i_cmp};
        ctl_next.rc_sy = {ctl_reg.rc_sy[1:0], i_rc_osc};
        if (ctl_reg.cmp_sy[1] == ctl_reg.cmp_sy[2])
            ctl_next.cmp_f = ctl_reg.cmp_sy[2];
        if (ctl_reg.rc_sy[1] == ctl_reg.rc_sy[2])
            ctl_next.rc_f = ctl_reg.rc_sy[2];

        // conversion engine
        unique case (ctl_reg.st)
            ACC_ST_IDLE:
                ctl_next.tad_cnt = 4'h0;
            // one instruction cycle before rc conversion
            ACC_ST_DELAY:
                if (ctl_reg.dly == 3'(`ACC_TCY_CYCLES - 1))
                    ctl_next.st = ACC_ST_CONV;
                else
                    ctl_next.dly = ctl_reg.dly + 3'h1;
            ACC_ST_CONV:
            begin
                if (tad)
                begin
                    if (ctl_reg.tad_cnt == 4'(`ACC_TAD_PER_CONV - 1))
                    begin
                        // result, go and done in one event
                        fin = 1'b1;
                        if (ctl_reg.justify)
                        begin
                            ctl_next.res_hi = {6'h00, ctl_reg.sar[9:8]};
                            ctl_next.res_lo = ctl_reg.sar[7:0];
                        end
                        else
                        begin
                            ctl_next.res_hi = ctl_reg.sar[9:2];
                            ctl_next.res_lo = {ctl_reg.sar[1:0], 6'h00};
                        end
                        ctl_next.go = 1'b0;
                        ctl_next.done = 1'b1;
                        ctl_next.st = ACC_ST_IDLE;
                    end
                    else
                    begin
                        ctl_next.tad_cnt = ctl_reg.tad_cnt + 4'h1;
                        if (ctl_reg.tad_cnt != 4'h0)
                        begin
                            bidx = 4'hA - ctl_reg.tad_cnt;
                            ctl_next.sar[bidx] = ctl_reg.cmp_f;
                            if (bidx != 4'h0)
                                ctl_next.sar[bidx - 4'h1] = 1'b1;
                        end
                    end
                end
            end
            default:
            begin
                ctl_next.st = ACC_ST_IDLE;
                ctl_next.go = 1'b0;
            end
        endcase

        // only the rc clock survives sleep
        if (i_sleep && ctl_reg.clk_sel != `ACC_CLK_RC && ctl_reg.st != ACC_ST_IDLE)
        begin
            ctl_next.go = 1'b0;
            ctl_next.st = ACC_ST_IDLE;
        end

        // apb answer in the access phase after setup
        ctl_next.pready = setup;
        if (setup)
        begin
            ctl_next.pslverr = 1'b0;
            ctl_next.prdata = 32'h0000_0000;
            if (hit && idx == `ACC_IDX_CTRL_A)
                ctl_next.prdata[7:0] = {ctl_reg.clk_sel, ctl_reg.chan, ctl_reg.go,
                    1'b0, ctl_reg.on};
            else if (hit && idx == `ACC_IDX_CTRL_B)
                ctl_next.prdata[7:0] = {ctl_reg.justify, 3'h0, ctl_reg.pcfg};
            else if (hit && idx == `ACC_IDX_RES_HI)
                ctl_next.prdata[7:0] = ctl_reg.res_hi;
            else if (hit && idx == `ACC_IDX_RES_LO)
                ctl_next.prdata[7:0] = ctl_reg.res_lo;
            else if (hit && idx == `ACC_IDX_STATUS)
            begin
                ctl_next.prdata[`ACC_S_DONE_BIT] = ctl_reg.done;
                ctl_next.prdata[`ACC_S_BUSY_BIT] = ctl_reg.st != ACC_ST_IDLE;
            end
            else
                ctl_next.pslverr = 1'b1;
        end

        // register writes at the access edge
        if (access && i_pwrite && !ctl_reg.pslverr)
        begin
            if (idx == `ACC_IDX_CTRL_A)
            begin
                ctl_next.clk_sel = i_pwdata[`ACC_A_CLKSEL_LSB +: 2];
                ctl_next.chan = i_pwdata[`ACC_A_CHAN_LSB +: 3];
                ctl_next.on = i_pwdata[`ACC_A_ON_BIT];
                // off shuts the module and any conversion down
                if (!i_pwdata[`ACC_A_ON_BIT])
                begin
                    ctl_next.go = 1'b0;
                    ctl_next.st = ACC_ST_IDLE;
                end
                else if (i_pwdata[`ACC_A_GO_BIT] && !ctl_reg.go)
                begin
                    ctl_next.go = 1'b1;
                    ctl_next.dly = 3'h0;
                    ctl_next.tad_cnt = 4'h0;
                    ctl_next.sar = `ACC_SAR_FIRST;
                    if (i_pwdata[`ACC_A_CLKSEL_LSB +: 2] == `ACC_CLK_RC)
                        ctl_next.st = ACC_ST_DELAY;
                    else
                        ctl_next.st = ACC_ST_CONV;
                end
                // abort leaves result alone, a same-cycle completion keeps its load
                else if (!i_pwdata[`ACC_A_GO_BIT] && ctl_reg.go)
                begin
                    ctl_next.go = 1'b0;
                    ctl_next.st = ACC_ST_IDLE;
                end
            end
            else if (idx == `ACC_IDX_CTRL_B)
            begin
                ctl_next.justify = i_pwdata[`ACC_B_JUST_BIT];
                ctl_next.pcfg = i_pwdata[`ACC_B_PCFG_LSB +: 4];
            end
            else if (idx == `ACC_IDX_RES_HI && !fin)
                ctl_next.res_hi = i_pwdata[7:0];
            else if (idx == `ACC_IDX_RES_LO && !fin)
                ctl_next.res_lo = i_pwdata[7:0];
            // completion set wins over a clear
            else if (idx == `ACC_IDX_STATUS && !i_pwdata[`ACC_S_DONE_BIT] && !fin)
                ctl_next.done = 1'b0;
        end

        if (i_sys_rst)
        begin
            ctl_next = '0;
            {ctl_next.clk_sel, ctl_next.chan, ctl_next.go, ctl_next.on} =
                {CA_RST[7:2], CA_RST[0]};
            {ctl_next.justify, ctl_next.pcfg} = {CB_RST[7], CB_RST[3:0]};
        end

        pdec = pin_decode(ctl_next.pcfg);
        ctl_next.pin_an = i_sys_rst ? `ACC_PIN_AN_RST : pdec[4:0];
        ctl_next.vlo_pin = pdec[5];
        ctl_next.vhi_pin = pdec[6];
        ctl_next.powered = ctl_next.on && !(i_sleep && ctl_next.clk_sel != `ACC_CLK_RC);
        ctl_next.sample = ctl_next.powered && ctl_next.st == ACC_ST_IDLE;
    end

    always_ff @(posedge i_ref_clk)
    begin
        ctl_reg <= ctl_next;
    end

    assign o_pready = ctl_reg.pready;
    assign o_prdata = ctl_reg.prdata;
    assign o_pslverr = ctl_reg.pslverr;
    assign o_chan_sel = ctl_reg.chan;
    assign o_pin_analog = ctl_reg.pin_an;
    assign o_vref_hi_pin = ctl_reg.vhi_pin;
    assign o_vref_lo_pin = ctl_reg.vlo_pin;
    assign o_powered = ctl_reg.powered;
    assign o_sample = ctl_reg.sample;
    assign o_dac_code = ctl_reg.sar;
    assign o_done_flag = ctl_reg.done;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    logic [3:0] tad_seen;
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst || ctl_reg.st != ACC_ST_CONV)
            tad_seen <= 4'h0;
        else if (tad)
            tad_seen <= tad_seen + 4'h1;
    end

    chk_done_event: assert property (fin |=> ctl_reg.done && !ctl_reg.go && ctl_reg.sample)
        else $error("completion did not set done and clear go");
    chk_right_just: assert property (fin && ctl_reg.justify |=> ctl_reg.res_hi[7:2] == 6'h00)
        else $error("right justified high bits not zero");
    chk_left_just: assert property (fin && !ctl_reg.justify |=> ctl_reg.res_lo[5:0] == 6'h00)
        else $error("left justified low bits not zero");
    chk_go_running: assert property (ctl_reg.st != ACC_ST_IDLE |-> ctl_reg.go)
        else $error("go low while converting");
    chk_off_no_start: assert property (!ctl_reg.on |-> ctl_reg.st == ACC_ST_IDLE && !o_powered)
        else $error("converter off but active");
    chk_twelve_tad: assert property (fin |-> tad_seen == 4'hB)
        else $error("conversion not twelve bit periods");
    chk_abort_keeps: assert property (ctl_reg.go && !ctl_next.go && !fin && !i_sys_rst
        |=> $stable(ctl_reg.res_hi) && $stable(ctl_reg.res_lo) && !$rose(ctl_reg.done))
        else $error("abort disturbed result");
    chk_sleep_abort: assert property (i_sleep && ctl_reg.clk_sel != `ACC_CLK_RC
        && ctl_reg.st == ACC_ST_CONV |=> ctl_reg.st == ACC_ST_IDLE)
        else $error("sleep did not abort conversion");
    chk_rc_delay: assert property ($rose(ctl_reg.st == ACC_ST_DELAY)
        |-> ##3 ctl_reg.st == ACC_ST_DELAY ##1 ctl_reg.st == ACC_ST_CONV)
        else $error("rc start delay wrong");
    chk_digital_all: assert property (ctl_reg.pcfg[3:1] == 3'h3 |-> o_pin_analog == 5'h00)
        else $error("pins not digital");
    chk_ref_pins: assert property (ctl_reg.pcfg == 4'h8 |-> o_vref_hi_pin && o_vref_lo_pin)
        else $error("references not from pins");

    cov_full_conv: cover property (fin);
    cov_abort: cover property (ctl_reg.st == ACC_ST_CONV && !fin ##1 ctl_reg.st == ACC_ST_IDLE);
    cov_rc_conv: cover property (ctl_reg.st == ACC_ST_DELAY ##[1:4] ctl_reg.st == ACC_ST_CONV);

endmodule

// ===== verilog/acc_map.svh
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define ACC_IDX_CTRL_A 8'h1F
`define ACC_IDX_CTRL_B 8'h9F
`define ACC_IDX_RES_HI 8'h1E
`define ACC_IDX_RES_LO 8'h9E
`define ACC_IDX_STATUS 8'h20

// ==========================================================
// field positions
`define ACC_A_CLKSEL_LSB 6
`define ACC_A_CHAN_LSB 3
`define ACC_A_GO_BIT 2
`define ACC_A_ON_BIT 0
`define ACC_B_JUST_BIT 7
`define ACC_B_PCFG_LSB 0
`define ACC_S_DONE_BIT 0
`define ACC_S_BUSY_BIT 1

// ==========================================================
// reset values and codes
`define ACC_CTRL_A_RST 8'h00
`define ACC_CTRL_B_RST 8'h00
`define ACC_PIN_AN_RST 5'h1F
`define ACC_CLK_RC 2'h3
`define ACC_SAR_FIRST 10'h200

// ==========================================================
// timing
`define ACC_CLK_PERIOD_NS 100
`define ACC_TCY_NS 400
`define ACC_TCY_CYCLES ((`ACC_TCY_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
`define ACC_TAD_PER_CONV 12
`define ACC_DIV_CODE0 2
`define ACC_DIV_CODE1 8
`define ACC_DIV_CODE2 32

`endif

// ===== verilog/acc_pkg.sv
package acc_pkg;

    typedef enum logic [1:0]
    {
        ACC_ST_IDLE = 2'b00,
        ACC_ST_DELAY = 2'b01,
        ACC_ST_CONV = 2'b10
    } acc_state_t;

    typedef struct packed {
        logic [1:0] clk_sel;
        logic [2:0] chan;
        logic go;
        logic on;
        logic justify;
        logic [3:0] pcfg;
        logic [7:0] res_hi;
        logic [7:0] res_lo;
        logic done;
        acc_state_t st;
        logic [3:0] tad_cnt;
        logic [2:0] dly;
        logic [9:0] sar;
        logic [2:0] cmp_sy;
        logic cmp_f;
        logic [2:0] rc_sy;
        logic rc_f;
        logic [4:0] pin_an;
        logic vhi_pin;
        logic vlo_pin;
        logic powered;
        logic sample;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } acc_ctl_t;

    typedef struct packed {
        logic [5:0] cnt;
        logic rc_prev;
        logic tad;
    } acc_tad_t;

endpackage

// ===== verilog/acc_tad_div.sv
`timescale 1ns/1ps
`include "acc_map.svh"

module acc_tad_div
    import acc_pkg::*;
#(
    parameter int DIV0 = `ACC_DIV_CODE0,
    parameter int DIV1 = `ACC_DIV_CODE1,
    parameter int DIV2 = `ACC_DIV_CODE2
)
(
    input logic i_ref_clk,    // system clock
    input logic i_sys_rst,    // sync reset, active high
    input logic i_run,        // conversion running
    input logic [1:0] i_sel,  // conversion clock select
    input logic i_rc_lvl,     // filtered rc oscillator level
    output logic o_tad        // one-cycle per-bit pulse
);

    acc_tad_t tad_reg;
    acc_tad_t tad_next;
    logic [5:0] lim;

    always_comb
    begin
        unique case (i_sel)
            2'h0: lim = 6'(DIV0 - 1);
            2'h1: lim = 6'(DIV1 - 1);
            default: lim = 6'(DIV2 - 1);
        endcase
        tad_next = tad_reg;
        tad_next.tad = 1'b0;
        if (i_sys_rst)
        begin
            tad_next = '0;
        end
        else if (!i_run)
        begin
            tad_next.cnt = 6'h00;
            tad_next.rc_prev = i_rc_lvl;
        end
        else if (i_sel == `ACC_CLK_RC)
        begin
            tad_next.tad = i_rc_lvl && !tad_reg.rc_prev;
            tad_next.rc_prev = i_rc_lvl;
        end
        else if (tad_reg.cnt == lim)
        begin
            tad_next.cnt = 6'h00;
            tad_next.tad = 1'b1;
        end
        else
        begin
            tad_next.cnt = tad_reg.cnt + 6'h01;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        tad_reg <= tad_next;
    end

    assign o_tad = tad_reg.tad;

endmodule
